// >>> design/wdps_top.sv
// watchdog tick divider, counter and two time-out events
// assumes the slow oscillator clock arrives as an asynchronous pin and
// control comes from logic on clk_in
// Summary of operation
// - four-bit select picks 2048 doubling to 1048576 ticks; 10-15 reserved
// - early warning at selected count; time-out at twice that count
// - divider setting 2: tick clock is slow oscillator divided by five
// - divider setting 3: tick clock is slow oscillator divided by seven
// - divider setting 4: tick clock is slow oscillator divided by nine
`timescale 1ns/100ps
`default_nettype none
module wdps_top
  import wdps_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic slow_oscillator_clock_in,
  input wire logic restart_in,
  input wire wdps_ctrl_type ctrl_in,
  output var wdps_event_type event_out,
  output logic reserved_select_out,
  output logic watchdog_tick_clock_out
);

  // ==========================================================
  // synchroniser and edge detect
  logic sync1_q, sync2_q, sync3_q;
  logic osc_rise;
  // two flops for the asynchronous pin, a third only for edge detect
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= slow_oscillator_clock_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  // one-cycle strobe on each rising edge of the synchronised oscillator
  assign osc_rise = sync2_q & ~sync3_q;

  // ==========================================================
  // odd divider producing one tick per ratio oscillator edges
  logic [3:0] ratio;
  logic [3:0] div_q, div_d;
  logic tick_q, tick_d;
  logic valid_div;
  // ratio for the selected setting; any other setting stops the divider
  always_comb begin
    valid_div = 1'b1;
    case (ctrl_in.div_sel)
      DIV_SEL_2: ratio = RATIO_2;
      DIV_SEL_3: ratio = RATIO_3;
      DIV_SEL_4: ratio = RATIO_4;
      default: begin
        ratio = RATIO_2;
        valid_div = 1'b0;
      end
    endcase
  end

  // count oscillator edges and pulse the tick on the last one
  always_comb begin
    div_d = div_q;
    tick_d = 1'b0;
    if (!ctrl_in.enable || !valid_div || restart_in) begin
      div_d = 4'h0;
    end else if (osc_rise) begin
      if (div_q >= ratio - 4'h1) begin
        div_d = 4'h0;
        tick_d = 1'b1;
      end else begin
        div_d = div_q + 4'h1;
      end
    end
  end

  // divider registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // ==========================================================
  // tick counter and time-out compare
  logic [CNT_W-1:0] cnt_q, cnt_d, first_cnt;
  logic reserved;
  wdps_event_type ev_q, ev_d;
  assign reserved = ctrl_in.timeout_select > SEL_MAX_VALID;
  assign first_cnt = reserved ? '0 :
    CNT_W'(1) << (BASE_LOG2 + 32'(ctrl_in.timeout_select));

  // step on each tick, flag both time-outs, wrap after the second
  always_comb begin
    cnt_d = cnt_q;
    ev_d = '0;
    if (!ctrl_in.enable || reserved || restart_in) begin
      cnt_d = '0;
    end else if (tick_q) begin
      cnt_d = cnt_q + CNT_W'(1);
      if (cnt_d == first_cnt) begin
        ev_d.early_warning = 1'b1;
      end
      if (cnt_d == (first_cnt << 1)) begin
        ev_d.timeout = 1'b1;
        cnt_d = '0;
      end
    end
  end

  // counter and event registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      ev_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      ev_q <= ev_d;
    end
  end

  // outputs
  assign event_out = ev_q;
  assign reserved_select_out = reserved;
  assign watchdog_tick_clock_out = tick_q;

  // ==========================================================
  // checks
  property p_early_cnt;
    @(posedge clk_in) disable iff (!rst_b_in)
      ev_q.early_warning |-> cnt_q == first_cnt;
  endproperty
  a_early_cnt: assert property (p_early_cnt)
    else $error("early warning at wrong count");

  property p_timeout_wrap;
    @(posedge clk_in) disable iff (!rst_b_in)
      ev_q.timeout |-> cnt_q == '0 && $past(cnt_q) == (first_cnt << 1) - 1;
  endproperty
  a_timeout_wrap: assert property (p_timeout_wrap)
    else $error("timeout not at twice count");

  property p_reserved_quiet;
    @(posedge clk_in) disable iff (!rst_b_in)
      reserved && $past(reserved) |-> ev_q == '0;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet)
    else $error("event with reserved select");

  property p_cnt_step;
    @(posedge clk_in) disable iff (!rst_b_in)
      $past(tick_q) && $past(ctrl_in.enable) && !$past(restart_in)
      && !$past(reserved) && !ev_q.timeout
      |-> cnt_q == CNT_W'($past(cnt_q) + 1);
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("counter did not step on tick");

  property p_div5;
    @(posedge clk_in) disable iff (!rst_b_in)
      tick_d && ctrl_in.div_sel == DIV_SEL_2 |-> div_q == 4'h4;
  endproperty
  a_div5: assert property (p_div5)
    else $error("divide by five broken");

  property p_div7;
    @(posedge clk_in) disable iff (!rst_b_in)
      tick_d && ctrl_in.div_sel == DIV_SEL_3 |-> div_q == 4'h6;
  endproperty
  a_div7: assert property (p_div7)
    else $error("divide by seven broken");

  property p_div9;
    @(posedge clk_in) disable iff (!rst_b_in)
      tick_d && ctrl_in.div_sel == DIV_SEL_4 |-> div_q == 4'h8;
  endproperty
  a_div9: assert property (p_div9)
    else $error("divide by nine broken");

  property p_tick_single;
    @(posedge clk_in) disable iff (!rst_b_in)
      tick_q |=> !tick_q;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("tick longer than one cycle");

  property p_early_pulse;
    @(posedge clk_in) disable iff (!rst_b_in)
      ev_q.early_warning |=> !ev_q.early_warning;
  endproperty
  a_early_pulse: assert property (p_early_pulse)
    else $error("early warning longer than one cycle");

  property p_timeout_pulse;
    @(posedge clk_in) disable iff (!rst_b_in)
      ev_q.timeout |=> !ev_q.timeout;
  endproperty
  a_timeout_pulse: assert property (p_timeout_pulse)
    else $error("timeout longer than one cycle");

  property p_held_idle;
    @(posedge clk_in) disable iff (!rst_b_in)
      $past(!ctrl_in.enable) || $past(restart_in)
      |-> !tick_q && cnt_q == '0 && ev_q == '0;
  endproperty
  a_held_idle: assert property (p_held_idle)
    else $error("activity while stopped or restarted");

  property p_bad_div_still;
    @(posedge clk_in) disable iff (!rst_b_in)
      $past(!valid_div) |-> !tick_q;
  endproperty
  a_bad_div_still: assert property (p_bad_div_still)
    else $error("tick with unused divider setting");

endmodule : wdps_top
`default_nettype wire

// >>> design/wdps_pkg.sv
// package for the watchdog prescale and time-out select block
// assumes a single 25 MHz system clock domain
package wdps_pkg;

  // ==========================================================
  // prescale field
  localparam int unsigned SEL_W = 4;
  localparam logic [3:0] SEL_MAX_VALID = 4'h9; // codes above are reserved
  localparam int unsigned BASE_LOG2 = 11; // code 0 -> 2048 ticks
  localparam int unsigned CNT_W = 22; // holds 2 x 1048576

  // ==========================================================
  // tick divider settings and ratios
  localparam logic [2:0] DIV_SEL_2 = 3'h2;
  localparam logic [2:0] DIV_SEL_3 = 3'h3;
  localparam logic [2:0] DIV_SEL_4 = 3'h4;
  localparam logic [3:0] RATIO_2 = 4'h5;
  localparam logic [3:0] RATIO_3 = 4'h7;
  localparam logic [3:0] RATIO_4 = 4'h9;

  // control bundle
  typedef struct packed {
    logic enable;
    logic [2:0] div_sel;
    logic [SEL_W-1:0] timeout_select;
  } wdps_ctrl_type;

  // event bundle
  typedef struct packed {
    logic early_warning;
    logic timeout;
  } wdps_event_type;

endpackage : wdps_pkg

// >>> testbench/wdps_top_tb.sv
// self-checking bench for the watchdog tick divider and time-out events
// assumes a free-running slow oscillator at half the system clock rate
`timescale 1ns/100ps
`default_nettype none
module wdps_top_tb;
  import wdps_pkg::*;
  logic clk_in = 0, rst_b_in = 0, osc = 0, restart_in = 1, tick;
  logic reserved_select_out;
  wdps_ctrl_type ctrl_in = '0;
  wdps_event_type event_out;
  int mismatches = 0, checks_done = 0, ticks = 0, cyc = 0, last = 0;
  int ratio = 5, ew_exp = 2048, ews = 0, tos = 0;
  logic [31:0] rng = 32'h24F7;
  // ==========================================================
  // clock, oscillator and design
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) #1 osc = ~osc;
  wdps_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .slow_oscillator_clock_in(osc), .restart_in(restart_in),
    .ctrl_in(ctrl_in), .event_out(event_out),
    .reserved_select_out(reserved_select_out),
    .watchdog_tick_clock_out(tick));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // ==========================================================
  // model: tick spacing and tick count at each event, read at the
  // falling edge so that every registered output has settled
  always @(negedge clk_in) begin
    cyc++;
    if (tick === 1'b1) begin
      if (last != 0) check(cyc - last, 2 * ratio);
      last = cyc;
      ticks++;
    end
    if (event_out.early_warning === 1'b1) begin
      ews++;
      check(ticks, ew_exp);
    end
    if (event_out.timeout === 1'b1) begin
      tos++;
      check(ticks, 2 * ew_exp);
      ticks = 0;
    end
  end
  // restart, let the last tick drain, apply one setting, run n cycles
  task automatic run(input logic [2:0] d, input logic [3:0] s, input int n);
    @(posedge clk_in);
    #1 restart_in = 1;
    @(posedge clk_in);
    #1 ctrl_in = '{enable: 1'b1, div_sel: d, timeout_select: s};
    ratio = (d == DIV_SEL_2) ? RATIO_2 : (d == DIV_SEL_3) ? RATIO_3 : RATIO_4;
    ew_exp = 1 << (BASE_LOG2 + s);
    ticks = 0;
    last = 0;
    ews = 0;
    tos = 0;
    @(posedge clk_in);
    #1 restart_in = 0;
    repeat (n) @(posedge clk_in);
    $display("test div %0d sel %0d done", d, s);
  endtask : run
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_in);
    #1 rst_b_in = 1;
    run(DIV_SEL_2, 4'h0, 41100);
    check(ews, 1);
    check(tos, 1);
    run(DIV_SEL_2, 4'h1, 41100);
    check(ews, 1);
    check(tos, 0);
    run(DIV_SEL_3, 4'h0, 400);
    run(DIV_SEL_4, 4'h0, 400);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_in);
      #1 ctrl_in.timeout_select = 4'(i);
      #5 check(reserved_select_out, i > 9);
    end
    $display("test reserved flag done");
    rng = xs(rng);
    run(DIV_SEL_2, 4'(4'hA + rng % 6), 2000);
    check(ews + tos, 0);
    @(posedge clk_in);
    #1 restart_in = 1;
    @(posedge clk_in);
    #1 ticks = 0;
    repeat (100) @(posedge clk_in);
    check(ticks, 0);
    #1 restart_in = 0;
    ctrl_in.enable = 1'b0;
    repeat (100) @(posedge clk_in);
    check(ticks, 0);
    #1 ctrl_in = '{enable: 1'b1, div_sel: 3'h7, timeout_select: 4'h0};
    repeat (100) @(posedge clk_in);
    check(ticks, 0);
    check(ews + tos, 0);
    $display("test restart and idle done");
    end_of_test();
  end
  // watchdog: about 85,400 cycles are planned, 90,000 means a hang
  initial begin
    #3600000;
    mismatches++;
    end_of_test();
  end
endmodule : wdps_top_tb
`default_nettype wire
